// [rtl/pwr_ctrl_defs.vh]
// Offsets, field positions, reset values and timing counts of the block
`ifndef PWR_CTRL_DEFS_VH
`define PWR_CTRL_DEFS_VH

`define FRAME_BITS 16
`define ADDR_HI 14
`define ADDR_LO 11
`define DAC_WRITE_BIT 15
`define DAC_CH_HI 14
`define DAC_CH_LO 12
`define DAC_DATA_BITS 12

`define ADDR_READBACK_LOAD 4'h7
`define ADDR_POWER_REF 4'hb
`define ADDR_SOFT_RESET 4'hf

`define GLOBAL_PD_BIT 10
`define REF_EN_BIT 9
`define PD_HI 7
`define PD_LO 0

`define RB_EN_BIT 6
`define RB_SEL_HI 5
`define RB_SEL_LO 2
`define LOAD_MODE_HI 1
`define LOAD_MODE_LO 0

`define RB_NOP 4'h0
`define RB_DAC 4'h1
`define RB_ADC_SEQ 4'h2
`define RB_GP_CTRL 4'h3
`define RB_ADC_PINS 4'h4
`define RB_DAC_PINS 4'h5
`define RB_PULL_DOWN 4'h6

`define LOAD_DIRECT 2'h0
`define LOAD_HOLD 2'h1
`define LOAD_COPY_ALL 2'h2

`define PD_RESET 8'h00
`define GLOBAL_PD_RESET 1'b0
`define REF_EN_RESET 1'b0
`define LOAD_MODE_RESET 2'h0
`define RB_SEL_RESET 4'h0

`define MCLK_PERIOD_NS 100
`define RESET_TIME_US 250
`define RESET_CYCLES ((`RESET_TIME_US * 1000) / `MCLK_PERIOD_NS)

`endif

// [rtl/pin_sync.v]
// Two-flop synchroniser for inputs from outside the mclk domain
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire mclk,
    input wire rst_n,
    input wire ce,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;

    // First stage feeds only the second
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            sync_out <= RST_VAL;
        end else if (ce) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // pin_sync

// [rtl/power_reset_readback_ctrl.v]
// Power-down, reset, readback and load-mode control behind the serial port
//
// What this block does
// - Channel power-down bit acts only on DACs
// - Powered-down DAC output goes three-state
// - Returning channel resumes its previous output
// - Reference enable defaults off; set powers up
// - ADC off when no pin is ADC
// - Global power-down stops reference, DACs, ADC
// - Software reset restores all control defaults, DAC codes
// - Reset completes within 250 us; writes dropped
// - Reset pin falling edge equals software reset
// - Readback enable shifts register on next transfer
// - Readback enable self-clears after that transfer
// - Load-mode bits apply on every write
// - Select field picks the readback source
// - Mode 00 copies input to DAC immediately
// - Mode 01 holds data in input registers
// - Mode 10 copies all inputs, updates together
`timescale 1ns/1ps
`include "pwr_ctrl_defs.vh"
module power_reset_readback_ctrl #(
    parameter CHANNELS = 8,
    parameter DAC_BITS = `DAC_DATA_BITS,
    parameter RESET_CYCLES = `RESET_CYCLES
) (
    input wire mclk,
    input wire rst_n,
    input wire ce,
    input wire sclk,
    input wire sync_n,
    input wire sdi,
    output reg sdo,
    output reg sdo_oe,
    input wire reset_pin_n,
    input wire [CHANNELS-1:0] pin_is_dac,
    input wire [CHANNELS-1:0] pin_is_adc,
    input wire [15:0] adc_seq_word,
    input wire [15:0] gp_ctrl_word,
    input wire [15:0] adc_pins_word,
    input wire [15:0] dac_pins_word,
    input wire [15:0] pull_down_word,
    output reg [CHANNELS*DAC_BITS-1:0] dac_code,
    output wire [CHANNELS-1:0] dac_channel_power_down,
    output wire [CHANNELS-1:0] dac_out_tristate,
    output wire ref_enable,
    output wire adc_power_up,
    output reg [1:0] dac_load_mode,
    output reg readback_pending,
    output reg reset_busy
);
    localparam CNT_W = 16;

    wire sclk_s;
    wire sync_s;
    wire sdi_s;
    wire rpin_s;
    reg sclk_d;
    reg sync_d;
    reg rpin_d;
    reg [4:0] bit_cnt_r;
    reg [14:0] shift_in_r;
    reg [15:0] shift_out_r;
    reg rb_active_r;
    reg [CHANNELS-1:0] pd_r;
    reg global_pd_r;
    reg ref_en_r;
    reg [3:0] rb_sel_r;
    reg [2:0] last_ch_r;
    reg [CHANNELS*DAC_BITS-1:0] dac_input_r;
    reg [CNT_W-1:0] rst_cnt_r;
    integer i;

    pin_sync #(.WIDTH(4), .RST_VAL(4'b1110)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .async_in({sync_n, reset_pin_n, sdi, sclk}),
        .sync_out({sync_s, rpin_s, sdi_s, sclk_s})
    );

    wire sclk_fall = sclk_d & ~sclk_s;
    wire frame_start = sync_d & ~sync_s;
    wire rpin_fall = rpin_d & ~rpin_s;
    wire bit_take = sclk_fall & ~sync_s & (bit_cnt_r < 5'd16);
    wire frame_done = bit_take & (bit_cnt_r == 5'd15);
    wire [15:0] word = {shift_in_r, sdi_s};
    wire [3:0] addr = word[`ADDR_HI:`ADDR_LO];
    // Writes during the reset interval are dropped
    wire wr_ok = frame_done & ~reset_busy & ~word[`DAC_WRITE_BIT];
    wire wr_dac = frame_done & ~reset_busy & word[`DAC_WRITE_BIT];
    wire wr_power = wr_ok & (addr == `ADDR_POWER_REF);
    wire wr_rb = wr_ok & (addr == `ADDR_READBACK_LOAD);
    wire wr_soft_rst = wr_ok & (addr == `ADDR_SOFT_RESET);
    wire start_reset = wr_soft_rst | rpin_fall;
    wire [2:0] wr_ch = word[`DAC_CH_HI:`DAC_CH_LO];

    // Readback word for the selected source
    function [15:0] rb_word;
        input [3:0] sel;
        input [2:0] ch;
        input [CHANNELS*DAC_BITS-1:0] codes;
        begin
            case (sel)
                `RB_DAC: rb_word = {1'b1, ch,
                    codes[ch*DAC_BITS +: DAC_BITS]};
                `RB_ADC_SEQ: rb_word = adc_seq_word;
                `RB_GP_CTRL: rb_word = gp_ctrl_word;
                `RB_ADC_PINS: rb_word = adc_pins_word;
                `RB_DAC_PINS: rb_word = dac_pins_word;
                `RB_PULL_DOWN: rb_word = pull_down_word;
                default: rb_word = 16'h0000;
            endcase
        end
    endfunction

    // Edge detectors and serial shifter
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            sync_d <= 1'b1;
            rpin_d <= 1'b1;
            bit_cnt_r <= 5'd0;
            shift_in_r <= 15'h0000;
            shift_out_r <= 16'h0000;
            rb_active_r <= 1'b0;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else if (ce) begin
            sclk_d <= sclk_s;
            sync_d <= sync_s;
            rpin_d <= rpin_s;
            sdo <= shift_out_r[15];
            sdo_oe <= ~sync_s;
            if (frame_start) begin
                bit_cnt_r <= 5'd0;
                shift_in_r <= 15'h0000;
                rb_active_r <= readback_pending;
                if (readback_pending) begin
                    shift_out_r <= rb_word(rb_sel_r, last_ch_r, dac_code);
                end else begin
                    shift_out_r <= 16'h0000;
                end
            end else if (bit_take) begin
                bit_cnt_r <= bit_cnt_r + 5'd1;
                shift_in_r <= word[14:0];
                shift_out_r <= {shift_out_r[14:0], 1'b0};
                if (frame_done) begin
                    rb_active_r <= 1'b0;
                end
            end
        end
    end

    // Reset interval timer
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_r <= {CNT_W{1'b0}};
            reset_busy <= 1'b0;
        end else if (ce) begin
            if (start_reset) begin
                rst_cnt_r <= RESET_CYCLES[CNT_W-1:0] - 1'b1;
                reset_busy <= 1'b1;
            end else if (reset_busy) begin
                if (rst_cnt_r == {CNT_W{1'b0}}) begin
                    reset_busy <= 1'b0;
                end else begin
                    rst_cnt_r <= rst_cnt_r - 1'b1;
                end
            end
        end
    end

    // Control registers
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pd_r <= `PD_RESET;
            global_pd_r <= `GLOBAL_PD_RESET;
            ref_en_r <= `REF_EN_RESET;
            dac_load_mode <= `LOAD_MODE_RESET;
            rb_sel_r <= `RB_SEL_RESET;
            readback_pending <= 1'b0;
            last_ch_r <= 3'd0;
            dac_input_r <= {CHANNELS*DAC_BITS{1'b0}};
            dac_code <= {CHANNELS*DAC_BITS{1'b0}};
        end else if (ce) begin
            if (start_reset) begin
                pd_r <= `PD_RESET;
                global_pd_r <= `GLOBAL_PD_RESET;
                ref_en_r <= `REF_EN_RESET;
                dac_load_mode <= `LOAD_MODE_RESET;
                rb_sel_r <= `RB_SEL_RESET;
                readback_pending <= 1'b0;
                last_ch_r <= 3'd0;
                dac_input_r <= {CHANNELS*DAC_BITS{1'b0}};
                dac_code <= {CHANNELS*DAC_BITS{1'b0}};
            end else begin
                if (wr_power) begin
                    pd_r <= word[`PD_HI:`PD_LO];
                    global_pd_r <= word[`GLOBAL_PD_BIT];
                    ref_en_r <= word[`REF_EN_BIT];
                end
                // Readback end clears; a new request in that frame wins
                if (wr_rb && word[`RB_EN_BIT]) begin
                    readback_pending <= 1'b1;
                    rb_sel_r <= word[`RB_SEL_HI:`RB_SEL_LO];
                end else if (frame_done && rb_active_r) begin
                    readback_pending <= 1'b0;
                end
                if (wr_rb) begin
                    dac_load_mode <= word[`LOAD_MODE_HI:`LOAD_MODE_LO];
                    if (word[`LOAD_MODE_HI:`LOAD_MODE_LO] ==
                            `LOAD_COPY_ALL) begin
                        dac_code <= dac_input_r;
                    end
                end
                if (wr_dac) begin
                    last_ch_r <= wr_ch;
                    dac_input_r[wr_ch*DAC_BITS +: DAC_BITS] <=
                        word[DAC_BITS-1:0];
                    if (dac_load_mode == `LOAD_DIRECT) begin
                        dac_code[wr_ch*DAC_BITS +: DAC_BITS] <=
                            word[DAC_BITS-1:0];
                    end
                end
            end
        end
    end

    // Codes stay held while powered down, so the output comes back as before
    assign dac_channel_power_down =
        (pd_r | {CHANNELS{global_pd_r}}) & pin_is_dac;
    assign dac_out_tristate = dac_channel_power_down;
    assign ref_enable = ref_en_r & ~global_pd_r;
    assign adc_power_up = (|pin_is_adc) & ~global_pd_r;
endmodule // power_reset_readback_ctrl

// [test/prr_host.sv]
// Host serial master model that sends frames and captures replies
`timescale 1ns/1ps
module prr_host (
    input wire mclk,
    output reg sclk,
    output reg sync_n,
    output reg sdi,
    input wire sdo
);
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        sdi = 1'b0;
    end
    // Whole 16-bit frames, MSB first, bit taken on sclk fall
    task automatic frame(input logic [15:0] w, output logic [15:0] r);
        int i;
        sync_n <= 1'b0;
        repeat (4) @(posedge mclk);
        for (i = 15; i >= 0; i--) begin
            sdi <= w[i];
            repeat (4) @(posedge mclk);
            r[i] = sdo;
            sclk <= 1'b0;
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
        end
        repeat (4) @(posedge mclk);
        sync_n <= 1'b1;
        // Released data line must not keep showing the last bit
        sdi <= ~w[0];
        repeat (4) @(posedge mclk);
    endtask
endmodule // prr_host

// [test/prr_chk.sv]
// Port assertions for the power, reset and readback control block
`timescale 1ns/1ps
module prr_chk #(
    parameter RESET_CYCLES = 2500
) (
    input wire mclk,
    input wire rst_n,
    input wire sync_n,
    input wire reset_pin_n,
    input wire [7:0] pin_is_dac,
    input wire [7:0] pin_is_adc,
    input wire [95:0] dac_code,
    input wire [7:0] dac_channel_power_down,
    input wire [7:0] dac_out_tristate,
    input wire ref_enable,
    input wire adc_power_up,
    input wire [1:0] dac_load_mode,
    input wire readback_pending,
    input wire reset_busy
);
    reg [15:0] busy_cnt_r;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) busy_cnt_r <= 16'h0;
        else if (reset_busy) busy_cnt_r <= busy_cnt_r + 16'h1;
        else busy_cnt_r <= 16'h0;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence pin_drop_s;
        $fell(reset_pin_n) && !reset_busy;
    endsequence
    sequence busy_soon_s;
        ##[1:5] reset_busy;
    endsequence
    tristate_pd_a:
        assert property (dac_out_tristate == dac_channel_power_down)
        else $error("tristate differs from power-down");
    pd_dac_only_a:
        assert property ((dac_channel_power_down & ~pin_is_dac) == 8'h0)
        else $error("non-DAC channel powered down");
    adc_auto_off_a:
        assert property (pin_is_adc == 8'h0 |-> !adc_power_up)
        else $error("ADC up with no ADC pin");
    global_off_a:
        assert property (|pin_is_adc && !adc_power_up |-> !ref_enable
            && dac_channel_power_down == pin_is_dac)
        else $error("global power-down incomplete");
    reset_defaults_a:
        assert property ($rose(reset_busy) |-> dac_code == 96'h0
            && dac_load_mode == 2'h0 && !ref_enable && !readback_pending)
        else $error("reset left a non-default value");
    reset_bound_a:
        assert property (busy_cnt_r <= RESET_CYCLES)
        else $error("reset interval too long");
    pin_reset_a:
        assert property (pin_drop_s |-> busy_soon_s)
        else $error("reset pin fall ignored");
    pending_clear_a:
        assert property ($fell(readback_pending) |-> !sync_n || reset_busy)
        else $error("readback request cleared outside a frame");
    load_hold_a:
        assert property ($changed(dac_code) |-> $past(dac_load_mode) == 2'h0
            || $changed(dac_load_mode))
        else $error("DAC code moved while held");
endmodule // prr_chk
bind power_reset_readback_ctrl prr_chk #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
    .mclk(mclk), .rst_n(rst_n), .sync_n(sync_n), .reset_pin_n(reset_pin_n),
    .pin_is_dac(pin_is_dac), .pin_is_adc(pin_is_adc), .dac_code(dac_code),
    .dac_channel_power_down(dac_channel_power_down),
    .dac_out_tristate(dac_out_tristate), .ref_enable(ref_enable),
    .adc_power_up(adc_power_up), .dac_load_mode(dac_load_mode),
    .readback_pending(readback_pending), .reset_busy(reset_busy));

// [test/power_reset_readback_ctrl_bench.sv]
// Scenario bench for the power, reset and readback control block
`timescale 1ns/1ps
module power_reset_readback_ctrl_bench;
    localparam int RST_CYC = 400;
    reg mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, reset_pin_n = 1'b1;
    reg [7:0] pin_is_dac = 8'h0f, pin_is_adc = 8'h30;
    // Entry 1 is a DAC readback of channel 1 code 456: {1, ch, code}
    reg [15:0] w_tab [0:6] = '{16'h0, 16'h9456, 16'h1a2b, 16'h3c4d,
        16'h5e6f, 16'h7a8b, 16'h6f70};
    wire sclk, sync_n, sdi, sdo, ref_enable, adc_power_up;
    wire readback_pending, reset_busy, sdo_oe;
    wire [95:0] dac_code;
    wire [7:0] dac_channel_power_down, dac_out_tristate;
    wire [1:0] dac_load_mode;
    int n_fail = 0, n_tests = 0, cyc = 0, i;
    logic [15:0] rd;
    logic [3:0] s;
    power_reset_readback_ctrl #(.RESET_CYCLES(RST_CYC)) DUT (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .sync_n(sync_n),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .reset_pin_n(reset_pin_n),
        .pin_is_dac(pin_is_dac), .pin_is_adc(pin_is_adc),
        .adc_seq_word(w_tab[2]), .gp_ctrl_word(w_tab[3]),
        .adc_pins_word(w_tab[4]), .dac_pins_word(w_tab[5]),
        .pull_down_word(w_tab[6]), .dac_code(dac_code),
        .dac_channel_power_down(dac_channel_power_down),
        .dac_out_tristate(dac_out_tristate), .ref_enable(ref_enable),
        .adc_power_up(adc_power_up), .dac_load_mode(dac_load_mode),
        .readback_pending(readback_pending), .reset_busy(reset_busy));
    prr_host host (.mclk(mclk), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
        .sdo(sdo));
    always #50 mclk = ~mclk;
    task chk(input string nm, input logic [95:0] e, input logic [95:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task close_out;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task wr(input logic [15:0] w);
        host.frame(w, rd);
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        ce <= 1'b0;
        repeat (3) @(posedge mclk);
        ce <= 1'b1;
        chk("ref_enable", 1'h0, ref_enable);
        chk("load_mode", 2'h0, dac_load_mode);
        // Output driver must be on while a frame is open
        fork
            wr(16'h5a03);
            begin
                repeat (8) @(posedge mclk);
                chk("sdo_oe", 1'h1, sdo_oe);
            end
        join
        chk("sdo_oe", 1'h0, sdo_oe);
        chk("ref_enable", 1'h1, ref_enable);
        chk("tristate", 8'h03, dac_out_tristate);
        wr(16'h5a30);
        chk("pd", 8'h00, dac_channel_power_down);
        wr(16'ha123);
        chk("ch2", 12'h123, dac_code[35:24]);
        wr(16'h5a04);
        chk("tristate", 8'h04, dac_out_tristate);
        wr(16'h5a00);
        chk("ch2", 12'h123, dac_code[35:24]);
        wr(16'h5e00);
        chk("global", 10'h00f, {ref_enable, adc_power_up,
            dac_channel_power_down});
        wr(16'h5800);
        chk("adc_up", 1'h1, adc_power_up);
        @(posedge mclk) pin_is_adc <= 8'h00;
        @(posedge mclk) chk("adc_up", 1'h0, adc_power_up);
        wr(16'h3801);
        wr(16'h9456);
        chk("ch1", 12'h000, dac_code[23:12]);
        chk("load_mode", 2'h1, dac_load_mode);
        wr(16'h3802);
        chk("ch1", 12'h456, dac_code[23:12]);
        for (s = 4'h0; s < 4'h7; s++) begin
            wr({10'h0e1, s, 2'h1});
            chk("pending", 1'h1, readback_pending);
            chk("load_mode", 2'h1, dac_load_mode);
            host.frame(16'h0000, rd);
            chk("readback", w_tab[s], rd);
            chk("pending", 1'h0, readback_pending);
        end
        wr(16'h3805);
        chk("pending", 1'h0, readback_pending);
        wr(16'h5a03);
        wr(16'h7800);
        chk("busy", 1'h1, reset_busy);
        chk("code", 96'h0, dac_code);
        chk("ctrl", 3'h0, {ref_enable, dac_load_mode});
        wr(16'h5a03);
        chk("ref_enable", 1'h0, ref_enable);
        for (i = 0; i < RST_CYC && reset_busy; i++) @(posedge mclk);
        chk("busy", 1'h0, reset_busy);
        wr(16'h5a03);
        chk("ref_enable", 1'h1, ref_enable);
        reset_pin_n <= 1'b0;
        repeat (6) @(posedge mclk);
        chk("pin_reset", 2'h2, {reset_busy, ref_enable});
        reset_pin_n <= 1'b1;
        close_out();
    end
endmodule // power_reset_readback_ctrl_bench
